// [slesc_pkg.sv]
// Constants shared by the extended status and control block.
// Assumes a 32-bit AHB-Lite register bus and a baud-rate bit tick.
`default_nettype none

package slesc_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [31:0] SLESC_STAT_OFS = 32'h0000_0000; // Status reg
  localparam logic [31:0] SLESC_CTRL_OFS = 32'h0000_0004; // Control reg

  // ****************************************************************
  // Status register field positions
  // ****************************************************************
  localparam int SLESC_S_BRK    = 7; // Break detected flag
  localparam int SLESC_S_EDGE   = 6; // Receive edge flag
  localparam int SLESC_S_RX_INVERT  = 4; // Receive inversion
  localparam int SLESC_S_IDSEL  = 3; // Standby idle select
  localparam int SLESC_S_LBRK   = 2; // Long transmit break
  localparam int SLESC_S_LIN_BREAK_DETECT_EN  = 1; // Break detect enable
  localparam int SLESC_S_RAF    = 0; // Receiver active

  // ****************************************************************
  // Control register field positions
  // ****************************************************************
  localparam int SLESC_C_R8     = 7; // Received ninth bit
  localparam int SLESC_C_T8     = 6; // Transmit ninth bit
  localparam int SLESC_C_DIR    = 5; // Single-wire direction
  localparam int SLESC_C_TX_INVERT  = 4; // Transmit inversion
  localparam int SLESC_C_OVERRUN_IRQ_EN   = 3; // Overrun irq enable
  localparam int SLESC_C_NOISE_IRQ_EN   = 2; // Noise irq enable
  localparam int SLESC_C_FRAMING_IRQ_EN   = 1; // Framing irq enable
  localparam int SLESC_C_PARITY_IRQ_EN   = 0; // Parity irq enable

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] SLESC_STAT_RST = 8'h00; // Status reset
  localparam logic [7:0] SLESC_CTRL_RST = 8'h00; // Control reset

  // ****************************************************************
  // Bit-time counts
  // ****************************************************************
  localparam logic [3:0] SLESC_TX_BRK_SHORT = 4'hA; // 10 bit times
  localparam logic [3:0] SLESC_TX_BRK_LONG  = 4'hD; // 13 bit times
  localparam logic [3:0] SLESC_RX_BRK_SHORT = 4'hA; // 10 bit times
  localparam logic [3:0] SLESC_RX_BRK_LONG  = 4'hB; // 11 bit times
  localparam logic [3:0] SLESC_FRAME_SHORT  = 4'hA; // 10 bit times

endpackage : slesc_pkg

`default_nettype wire

// [slesc_rx_if.sv]
// Receive line carrier between the top and the input front end.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
`default_nettype none

interface slesc_rx_if;
  logic rx_invert;   // Receive inversion control
  logic single_wire; // Receive from transmit pin
  logic loop_int;    // Receive from internal loop
  logic rx_line;     // Selected, synced, de-inverted line
  logic edge_pulse;  // Active edge seen, one cycle

  modport front (input rx_invert, single_wire, loop_int,
                 output rx_line, edge_pulse);
  modport core  (output rx_invert, single_wire, loop_int,
                 input rx_line, edge_pulse);
endinterface : slesc_rx_if

`default_nettype wire

// [slesc_rx_front.sv]
// Receive front end: pin synchronisers, source select, inversion
// and active-edge detection. Assumes asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none

module slesc_rx_front
  import slesc_pkg::*;
(
  input  wire logic core_clk,  // Core clock
  input  wire logic rstn,      // Async reset, active low
  input  wire logic rxd_pin,   // Receive pin, async
  input  wire logic txp_pin,   // Transmit pin level, async
  input  wire logic loop_lvl,  // Internal loop level
  slesc_rx_if.front rif        // Control and line
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic rxd_s1; // First stage, read by second only
    logic rxd_s2; // Synced receive pin
    logic txp_s1; // First stage, read by second only
    logic txp_s2; // Synced transmit pin
    logic line;   // Previous raw line
  } slesc_front_s;

  slesc_front_s st_q;   // Registered state
  slesc_front_s st_d;   // Next state
  logic         src;    // Selected raw source
  logic         line_n; // Current de-inverted line

  // Source select, inversion, synchroniser chain
  always_comb begin
    st_d        = st_q;
    st_d.rxd_s1 = rxd_pin;
    st_d.rxd_s2 = st_q.rxd_s1;
    st_d.txp_s1 = txp_pin;
    st_d.txp_s2 = st_q.txp_s1;
    if (rif.single_wire) begin
      src = st_q.txp_s2;
    end else if (rif.loop_int) begin
      src = loop_lvl;
    end else begin
      src = st_q.rxd_s2;
    end
    line_n    = src ^ rif.rx_invert;
    st_d.line = src;
  end

  // State register, idle line is high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{default: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  // Raw line kept, so an inversion change alone is no pin edge
  assign rif.rx_line    = st_q.line ^ rif.rx_invert;
  assign rif.edge_pulse = (st_q.line ^ rif.rx_invert) & ~line_n;

endmodule : slesc_rx_front

`default_nettype wire

// [slesc_top.sv]
// Extended status and control of the serial unit: break detect and
// flag, receive edge flag, receiver active, line inversion, break
// lengths, ninth bits, single-wire direction and error irq enables.
// Assumes the baud generator gives one bit_tick per bit time at the
// bit centre and that the shifters and primary flags live outside.
//
// Contract
// - Break flag sets on enabled break; w1c
// - Edge flag on active input edge; w1c
// - Receive inversion covers every line level
// - Standby idle sets idle only if selected
// - Transmit break 10/11 or 13/14 bits
// - Receive break threshold 10/11 or 11/12
// - Break detect enable blocks framing, full flags
// - Active flag: start sets, idle clears
// - Ninth received bit above data byte
// - Ninth transmit bit loads with data byte
// - Single-wire pin direction follows control bit
// - Transmit inversion flips the output
// - Overrun irq when flag and enable
// - Noise irq when flag and enable
// - Framing irq when flag and enable
// - Parity irq when flag and enable
// - Frame is 10 or 11 bit times
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module slesc_top
  import slesc_pkg::*;
(
  input  wire logic        core_clk,         // Core clock, 125 MHz
  input  wire logic        rstn,             // Async reset, active low
  // AHB-Lite slave
  input  wire logic        hsel,             // Slave select
  input  wire logic [31:0] haddr,            // Address
  input  wire logic [1:0]  htrans,           // Transfer type
  input  wire logic        hwrite,           // Write access
  input  wire logic [2:0]  hsize,            // Transfer size
  input  wire logic [31:0] hwdata,           // Write data
  input  wire logic        hready,           // Bus ready
  output logic             hreadyout,        // Slave ready
  output logic             hresp,            // Response, always OKAY
  output logic [31:0]      hrdata,           // Read data
  // Unit configuration from elsewhere
  input  wire logic        bit_tick,         // One per bit time
  input  wire logic        m_mode,           // Nine data bits
  input  wire logic        loop_mode_sel,    // Loop mode
  input  wire logic        rx_source_sel,    // Receive source
  input  wire logic        tx_enable,        // Transmitter on
  // Receiver side
  input  wire logic        rxd_pin,          // Receive pin, async
  input  wire logic        rx_start_valid,   // Valid start bit
  input  wire logic        rx_idle_det,      // Idle line detected
  input  wire logic        rx_standby,       // Receiver in standby
  input  wire logic        rx_char_done,     // Character ready
  input  wire logic        rx_stop_bad,      // Stop bit was zero
  input  wire logic        rx_bit8,          // Ninth shifter bit
  input  wire logic        rx_full_flag,     // Receive buffer full
  output logic             rx_line,          // Conditioned line
  output logic             idle_flag_set,    // Idle flag may set
  output logic             rx_full_set,      // Full flag may set
  output logic             framing_set,      // Framing flag set
  output logic             break_seen,       // Break threshold met
  // Transmitter side
  input  wire logic        txd_shift,        // Shifter output level
  input  wire logic        tx_data_write,    // Data register written
  input  wire logic [7:0]  tx_data_byte,     // Byte written
  input  wire logic        tx_brk_req,       // Start a break
  output logic             tx_load,          // Load shifter pulse
  output logic [8:0]       tx_load_word,     // Word for shifter
  output logic             tx_brk_active,    // Break in progress
  output logic [3:0]       frame_bits,       // Frame length
  input  wire logic        txp_pin_i,        // Transmit pin level
  output logic             txp_pin_o,        // Transmit pin drive
  output logic             txp_pin_oe,       // Transmit pin enable
  // Primary error flags
  input  wire logic        overrun_flag,     // Overrun flag
  input  wire logic        noise_flag,       // Noise flag
  input  wire logic        framing_err_flag, // Framing flag
  input  wire logic        parity_err_flag,  // Parity flag
  output logic             irq_req           // Error irq request
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic        wr_stat;     // Pending write to status
    logic        wr_ctrl;     // Pending write to control
    logic [31:0] rdata;       // Read data
    logic        brk_flag;    // lin_break_flag
    logic        edge_flag;   // rx_edge_flag
    logic        rx_invert;   // Receive inversion
    logic        idle_sel;    // standby_idle_flag_sel
    logic        long_brk;    // long_break_tx
    logic        lin_break_detect_en;       // lin_break_detect_en
    logic        rx_active_flag;         // rx_active_flag
    logic        r8;          // rx_ninth_bit
    logic        t8;          // tx_ninth_bit
    logic        dir_out;     // single_wire_pin_output
    logic        tx_invert;   // Transmit inversion
    logic [3:0]  irq_en;      // Overrun, noise, framing, parity
    logic [3:0]  rx_lo_cnt;   // Low bit times seen
    logic        brk_done;    // Break reported this low run
    logic [3:0]  tx_brk_cnt;  // Break bits left
    logic        tx_brk;      // Break being sent
    logic        load;        // Shifter load pulse
    logic [8:0]  load_word;   // Word for shifter
  } slesc_top_s;

  slesc_top_s  st_q;          // Registered state
  slesc_top_s  st_d;          // Next state
  slesc_rx_if  rif ();        // Receive front carrier
  logic        addr_ok;       // Address phase accepted
  logic        single_wire;   // Single-wire mode
  logic        tx_core;       // Transmit level before inversion
  logic        tx_pin_lvl;    // Transmit level at pin
  logic [3:0]  rx_thresh;     // Receive break threshold
  logic [3:0]  tx_len;        // Transmit break length
  logic [7:0]  stat_v;        // Status view after update
  logic [7:0]  ctrl_v;        // Control view after update
  logic [3:0]  err_flags;     // Primary error flags

  // ****************************************************************
  // Receive front end
  // ****************************************************************
  assign single_wire     = loop_mode_sel & rx_source_sel;
  assign rif.rx_invert   = st_q.rx_invert;
  assign rif.single_wire = single_wire;
  assign rif.loop_int    = loop_mode_sel & ~rx_source_sel;

  // Synchronisers, source select and edge detection
  slesc_rx_front u_front (
    .core_clk (core_clk),
    .rstn     (rstn),
    .rxd_pin  (rxd_pin),
    .txp_pin  (txp_pin_i),
    .loop_lvl (tx_pin_lvl),
    .rif      (rif)
  );

  // ****************************************************************
  // Frame and break lengths
  // ****************************************************************
  // frame length by mode
  assign frame_bits = SLESC_FRAME_SHORT + {3'h0, m_mode};
  assign rx_thresh  = (st_q.lin_break_detect_en ? SLESC_RX_BRK_LONG : SLESC_RX_BRK_SHORT)
                      + {3'h0, m_mode};
  assign tx_len     = (st_q.long_brk ? SLESC_TX_BRK_LONG : SLESC_TX_BRK_SHORT)
                      + {3'h0, m_mode};

  // ****************************************************************
  // Transmit path and pin
  // ****************************************************************
  assign tx_core    = st_q.tx_brk ? 1'b0 : txd_shift;
  assign tx_pin_lvl = tx_core ^ st_q.tx_invert;
  assign txp_pin_o  = tx_pin_lvl;

  // Pin enable: direction bit only in single-wire mode
  always_comb begin
    if (single_wire) begin
      txp_pin_oe = tx_enable & st_q.dir_out;
    end else begin
      txp_pin_oe = tx_enable;
    end
  end

  // ****************************************************************
  // Receiver strobes and irq
  // ****************************************************************
  assign rx_line       = rif.rx_line;
  assign idle_flag_set = rx_idle_det & (~rx_standby | st_q.idle_sel);
  assign rx_full_set   = rx_char_done & ~st_q.lin_break_detect_en & ~rx_full_flag;
  assign framing_set   = rx_char_done & rx_stop_bad & ~st_q.lin_break_detect_en;
  assign break_seen    = bit_tick & ~rif.rx_line & ~st_q.brk_done
                         & (st_q.rx_lo_cnt + 4'h1 == rx_thresh);

  assign err_flags = {overrun_flag, noise_flag,
                      framing_err_flag, parity_err_flag};
  assign irq_req   = |(err_flags & st_q.irq_en);

  // ****************************************************************
  // Bus and transmit outputs, address accept
  // ****************************************************************
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = st_q.rdata;
  assign tx_load      = st_q.load;
  assign tx_load_word = st_q.load_word;
  assign tx_brk_active = st_q.tx_brk;
  assign addr_ok      = hsel & hready & htrans[1];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    st_d      = st_q;
    st_d.load = 1'b0;

    // Data phase of a status write
    if (st_q.wr_stat) begin
      st_d.rx_invert = hwdata[SLESC_S_RX_INVERT];
      st_d.idle_sel  = hwdata[SLESC_S_IDSEL];
      st_d.long_brk  = hwdata[SLESC_S_LBRK];
      st_d.lin_break_detect_en     = hwdata[SLESC_S_LIN_BREAK_DETECT_EN];
      if (hwdata[SLESC_S_BRK]) begin
        st_d.brk_flag = 1'b0;
      end
      if (hwdata[SLESC_S_EDGE]) begin
        st_d.edge_flag = 1'b0;
      end
    end

    // Data phase of a control write
    if (st_q.wr_ctrl) begin
      st_d.t8        = hwdata[SLESC_C_T8];
      st_d.dir_out   = hwdata[SLESC_C_DIR];
      st_d.tx_invert = hwdata[SLESC_C_TX_INVERT];
      st_d.irq_en    = hwdata[SLESC_C_OVERRUN_IRQ_EN:SLESC_C_PARITY_IRQ_EN];
    end

    if (break_seen && st_q.lin_break_detect_en) begin
      st_d.brk_flag = 1'b1;
    end
    if (rif.edge_pulse) begin
      st_d.edge_flag = 1'b1;
    end

    if (rx_start_valid) begin
      st_d.rx_active_flag = 1'b1;
    end else if (rx_idle_det) begin
      st_d.rx_active_flag = 1'b0;
    end

    if (rx_full_set) begin
      st_d.r8 = rx_bit8;
    end

    if (rif.rx_line) begin
      st_d.rx_lo_cnt = 4'h0;
      st_d.brk_done  = 1'b0;
    end else if (bit_tick && !st_q.brk_done) begin
      if (break_seen) begin
        st_d.brk_done  = 1'b1;
        st_d.rx_lo_cnt = 4'h0;
      end else begin
        st_d.rx_lo_cnt = st_q.rx_lo_cnt + 4'h1;
      end
    end

    if (!st_q.tx_brk && tx_brk_req) begin
      st_d.tx_brk     = 1'b1;
      st_d.tx_brk_cnt = tx_len;
    end else if (st_q.tx_brk && bit_tick) begin
      if (st_q.tx_brk_cnt == 4'h1) begin
        st_d.tx_brk = 1'b0;
      end
      st_d.tx_brk_cnt = st_q.tx_brk_cnt - 4'h1;
    end

    if (tx_data_write) begin
      st_d.load      = 1'b1;
      st_d.load_word = {(m_mode & st_d.t8), tx_data_byte};
    end

    // Register views after this cycle's updates
    stat_v = 8'h00;
    stat_v[SLESC_S_BRK]   = st_d.brk_flag;
    stat_v[SLESC_S_EDGE]  = st_d.edge_flag;
    stat_v[SLESC_S_RX_INVERT] = st_d.rx_invert;
    stat_v[SLESC_S_IDSEL] = st_d.idle_sel;
    stat_v[SLESC_S_LBRK]  = st_d.long_brk;
    stat_v[SLESC_S_LIN_BREAK_DETECT_EN] = st_d.lin_break_detect_en;
    stat_v[SLESC_S_RAF]   = st_d.rx_active_flag;
    ctrl_v = {st_d.r8, st_d.t8, st_d.dir_out, st_d.tx_invert,
              st_d.irq_en};

    // Address phase decode
    st_d.wr_stat = 1'b0;
    st_d.wr_ctrl = 1'b0;
    st_d.rdata   = 32'h0000_0000;
    if (addr_ok && haddr == SLESC_STAT_OFS) begin
      st_d.wr_stat = hwrite;
      st_d.rdata   = hwrite ? 32'h0000_0000 : {24'h00_0000, stat_v};
    end else if (addr_ok && haddr == SLESC_CTRL_OFS) begin
      st_d.wr_ctrl = hwrite;
      st_d.rdata   = hwrite ? 32'h0000_0000 : {24'h00_0000, ctrl_v};
    end else begin
      // Unmapped: reads zero, writes dropped
      st_d.rdata = 32'h0000_0000;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : slesc_top

`default_nettype wire

// [slesc_chk.sv]
// Checker on slesc_top ports.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none

module slesc_chk
  import slesc_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       m_mode,
  input wire logic       rx_idle_det,
  input wire logic       rx_standby,
  input wire logic       rx_char_done,
  input wire logic       rx_stop_bad,
  input wire logic       rx_full_flag,
  input wire logic       idle_flag_set,
  input wire logic       rx_full_set,
  input wire logic       framing_set,
  input wire logic       tx_data_write,
  input wire logic [7:0] tx_data_byte,
  input wire logic       tx_brk_req,
  input wire logic       tx_load,
  input wire logic [8:0] tx_load_word,
  input wire logic       tx_brk_active,
  input wire logic [3:0] frame_bits,
  input wire logic       overrun_flag,
  input wire logic       noise_flag,
  input wire logic       framing_err_flag,
  input wire logic       parity_err_flag,
  input wire logic       irq_req
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Data write, then load of the same byte
  sequence s_wr; tx_data_write; endsequence
  sequence s_ld; tx_load && tx_load_word[7:0] == $past(tx_data_byte); endsequence

  property p_bus; hreadyout && !hresp; endproperty
  property p_irq; !(overrun_flag | noise_flag | framing_err_flag | parity_err_flag) |-> !irq_req;
  endproperty
  property p_full; rx_full_set |-> rx_char_done && !rx_full_flag; endproperty
  property p_fram; framing_set |-> rx_char_done && rx_stop_bad; endproperty
  property p_idle; (!rx_standby || !rx_idle_det) |-> idle_flag_set == rx_idle_det; endproperty
  property p_load; s_wr |=> s_ld; endproperty
  property p_t8; tx_load && !m_mode |-> !tx_load_word[8]; endproperty
  property p_frm; frame_bits == (m_mode ? 4'hB : 4'hA); endproperty
  property p_brk; tx_brk_req && !tx_brk_active |=> tx_brk_active; endproperty
  property p_brkmin; $rose(tx_brk_active) |-> tx_brk_active[*8]; endproperty

  a_bus: assert property (p_bus) else $error("bus answer not ready okay");
  a_irq: assert property (p_irq) else $error("irq without flag");
  a_full: assert property (p_full) else $error("full set wrongly");
  a_fram: assert property (p_fram) else $error("framing set wrongly");
  a_idle: assert property (p_idle) else $error("idle set gating");
  a_load: assert property (p_load) else $error("tx load missing");
  a_t8: assert property (p_t8) else $error("ninth bit in 8-bit mode");
  a_frm: assert property (p_frm) else $error("frame length");
  a_brk: assert property (p_brk) else $error("break not started");
  a_brkmin: assert property (p_brkmin) else $error("break too short");
endmodule : slesc_chk

bind slesc_top slesc_chk u_slesc_chk (.*);

`default_nettype wire

// [slesc_node.sv]
// Remote node driving the receive pin.
// Assumes four cycles per bit.
`timescale 1ns/1ps
`default_nettype none

module slesc_node (
  input  wire logic core_clk, // Core clock
  input  wire logic inv,      // Line polarity inverted
  output logic      rxd       // Receive pin drive
);
  // mark level idles, flipped when inverted
  logic space = 1'h0; // Space being sent
  assign rxd = inv ^ ~space;

  // space run of n bits, then back to mark
  task automatic send_low(input int n);
    space <= 1'h1;
    repeat (n * 4) @(posedge core_clk);
    space <= 1'h0;
  endtask : send_low
endmodule : slesc_node

`default_nettype wire

// [serial_lin_ext_status_ctrl_tb.sv]
// Self-checking bench for slesc_top.
// Assumes a bit tick every four cycles, pulled-up tx pin.
`timescale 1ns/1ps
`default_nettype none

module serial_lin_ext_status_ctrl_tb;
  import slesc_pkg::*;
  logic core_clk, rstn, hsel, hwrite, m_mode, loop_mode_sel, rx_source_sel, tx_enable;
  logic rx_start_valid, rx_idle_det, rx_standby, rx_char_done, rx_stop_bad, rx_bit8;
  logic rx_full_flag, txd_shift, tx_data_write, tx_brk_req, node_inv;
  logic overrun_flag, noise_flag, framing_err_flag, parity_err_flag;
  logic [31:0] haddr, hwdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  tx_data_byte, q, cfg;
  logic [1:0]  tcnt = 2'h0;
  logic        bit_tick = 1'h0;
  wire logic hreadyout, hresp, rx_line, idle_flag_set, rx_full_set, framing_set, break_seen;
  wire logic tx_load, tx_brk_active, txp_pin_o, txp_pin_oe, irq_req, rxd_pin, txp_pin_i;
  wire logic [31:0] hrdata;
  wire logic [8:0]  tx_load_word;
  wire logic [3:0]  frame_bits;
  int fails, total_checks, cyc, k, n;

  // Released tx pin floats up
  assign txp_pin_i = txp_pin_oe ? txp_pin_o : 1'h1;

  slesc_top u_slesc_top (.*, .hready(hreadyout));
  slesc_node u_slesc_node (.core_clk, .inv(node_inv), .rxd(rxd_pin));

  // ****************************************************************
  // Clock, bit tick, timeout
  // ****************************************************************
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    tcnt <= tcnt + 2'h1;
    bit_tick <= (tcnt == 2'h3);
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      fails = fails + 1;
      print_verdict();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks = total_checks + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("unexpected t=%0t got %h exp %h", $time, s, e);
    end
  endtask : chk
  // One single AHB-Lite word transfer
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge core_clk);
    hsel <= 1'h1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0; htrans <= 2'h0; hwdata <= {24'h0, d};
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    q = hrdata[7:0];
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [7:0] d); bus(1'h1, a, d); endtask : wr
  task automatic rd(input logic [31:0] a); bus(1'h0, a, 8'h0); endtask : rd
  task automatic print_verdict;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {hsel, hwrite, m_mode, loop_mode_sel, rx_source_sel, rx_start_valid, rx_idle_det} = '0;
    {rx_standby, rx_char_done, rx_stop_bad, rx_bit8, rx_full_flag, tx_data_write} = '0;
    {tx_brk_req, node_inv, overrun_flag, noise_flag, framing_err_flag, parity_err_flag} = '0;
    {haddr, hwdata, htrans, tx_data_byte} = '0;
    {fails, total_checks, cyc} = '0;
    hsize = 3'h2; tx_enable = 1'h1; txd_shift = 1'h1; rstn = 1'h0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'h1;
    rd(SLESC_STAT_OFS); chk(q, SLESC_STAT_RST);
    rd(SLESC_CTRL_OFS); chk(q, SLESC_CTRL_RST);
    rd(32'h8); chk(q, 8'h0);
    wr(SLESC_CTRL_OFS, 8'hFF); rd(SLESC_CTRL_OFS); chk(q, 8'h7F);
    wr(SLESC_STAT_OFS, 8'hFF); rd(SLESC_STAT_OFS); chk(q, 8'h1E);
    wr(SLESC_STAT_OFS, 8'h0);
    $display("test registers done");
    for (k = 0; k < 4; k++) begin
      wr(SLESC_CTRL_OFS, 8'h0F);
      @(posedge core_clk);
      {overrun_flag, noise_flag, framing_err_flag, parity_err_flag} <= 4'h1 << k;
      @(posedge core_clk); #1 chk(irq_req, 1'h1);
      wr(SLESC_CTRL_OFS, 8'h0F ^ (8'h1 << k));
      #1 chk(irq_req, 1'h0);
    end
    {overrun_flag, noise_flag, framing_err_flag, parity_err_flag} <= 4'h0;
    $display("test irq done");
    wr(SLESC_CTRL_OFS, 8'h50);
    #1 chk(txp_pin_o, 1'h0);
    @(posedge core_clk); m_mode <= 1'h1; tx_data_byte <= 8'hA5; tx_data_write <= 1'h1;
    @(posedge core_clk); tx_data_write <= 1'h0;
    #1 chk({tx_load, tx_load_word}, 10'h3A5);
    @(posedge core_clk); loop_mode_sel <= 1'h1; rx_source_sel <= 1'h1;
    @(posedge core_clk); #1 chk(txp_pin_oe, 1'h0);
    wr(SLESC_CTRL_OFS, 8'h20);
    #1 chk(txp_pin_oe, 1'h1);
    @(posedge core_clk); loop_mode_sel <= 1'h0; rx_source_sel <= 1'h0;
    wr(SLESC_CTRL_OFS, 8'h0);
    $display("test transmit done");
    for (k = 0; k < 4; k++) begin
      wr(SLESC_STAT_OFS, {5'h0, k[1], 2'h0});
      @(posedge core_clk); m_mode <= k[0]; tx_brk_req <= 1'h1;
      @(posedge core_clk); tx_brk_req <= 1'h0;
      n = 0;
      do begin
        @(posedge core_clk);
        n += (tx_brk_active && bit_tick);
      end while (tx_brk_active === 1'h1);
      chk(n, (k[1] ? SLESC_TX_BRK_LONG : SLESC_TX_BRK_SHORT) + k[0]);
      chk(frame_bits, SLESC_FRAME_SHORT + k[0]);
    end
    $display("test tx break done");
    // long threshold chosen on half the runs
    for (k = 0; k < 8; k++) begin
      cfg = {3'h0, k[2], 2'h0, k[1], 1'h0};
      @(posedge core_clk); node_inv <= k[2]; m_mode <= k[0];
      wr(SLESC_STAT_OFS, cfg);
      repeat (8) @(posedge core_clk);
      wr(SLESC_STAT_OFS, cfg | 8'hC0);
      fork
        u_slesc_node.send_low(16);
        begin
          n = 0;
          do begin
            @(posedge core_clk);
            n += (rx_line === 1'h0 && bit_tick);
          end while (break_seen !== 1'h1 && n < 20);
        end
      join
      chk(n, (k[1] ? SLESC_RX_BRK_LONG : SLESC_RX_BRK_SHORT) + k[0]);
      wr(SLESC_STAT_OFS, cfg); rd(SLESC_STAT_OFS);
      chk(q, cfg | {k[1], 7'h40});
      wr(SLESC_STAT_OFS, cfg | 8'hC0); rd(SLESC_STAT_OFS);
      chk(q, cfg);
    end
    wr(SLESC_STAT_OFS, 8'h0);
    $display("test rx break done");
    @(posedge core_clk); m_mode <= 1'h0; rx_start_valid <= 1'h1;
    @(posedge core_clk); rx_start_valid <= 1'h0;
    rd(SLESC_STAT_OFS); chk(q[0], 1'h1);
    @(posedge core_clk); rx_idle_det <= 1'h1;
    @(posedge core_clk); rx_idle_det <= 1'h0;
    rd(SLESC_STAT_OFS); chk(q[0], 1'h0);
    @(posedge core_clk); rx_standby <= 1'h1; rx_idle_det <= 1'h1;
    @(posedge core_clk); #1 chk(idle_flag_set, 1'h0);
    wr(SLESC_STAT_OFS, 8'h08);
    #1 chk(idle_flag_set, 1'h1);
    @(posedge core_clk); rx_idle_det <= 1'h0; rx_standby <= 1'h0;
    rx_bit8 <= 1'h1; rx_char_done <= 1'h1; rx_stop_bad <= 1'h1;
    #1 chk({rx_full_set, framing_set}, 2'h3);
    @(posedge core_clk); rx_char_done <= 1'h0;
    rd(SLESC_CTRL_OFS); chk(q[7], 1'h1);
    wr(SLESC_STAT_OFS, 8'h02);
    @(posedge core_clk); rx_char_done <= 1'h1; rx_bit8 <= 1'h0;
    #1 chk({rx_full_set, framing_set}, 2'h0);
    @(posedge core_clk); rx_char_done <= 1'h0;
    rd(SLESC_CTRL_OFS); chk(q[7], 1'h1);
    $display("test receive flags done");
    print_verdict();
  end
endmodule : serial_lin_ext_status_ctrl_tb

`default_nettype wire
